/* File: src/clf_config_port.sv */
/*
  Configuration latch write port with link fault summary.
  Holds the receive rate select, signal detect amplitude select and receive
  enable latches; drives the active-low link fault output from the analog,
  range and density detectors, the local clock pin and a training clock
  watchdog. Assumes all inputs are synchronous to clk_in.
*/
// Overview of operation
// - Link fault on rate out of range, rx off, forced local clock or missing training clock.
// - Link fault also asserts when amplitude is below the level set by the amplitude select.
// - Link fault also asserts when transition density drops below the minimum.
// - A write strobe stores data bit 0, bits 1:0 or all 7 bits into the latch picked by the address.
// - Reset forces every latch to its initial value regardless of earlier writes.
// - A 2-bit amplitude select latch sets the trip level of the amplitude detector.
// - A receive rate select latch sets the clock rate of the receive channel.
// - Each static select input decodes to low, mid or high.
// - Link fault is active low: low while any fault holds, high only when none does.
// - While local clock is forced low, the recovery PLL locks to the training clock.
`timescale 1ns/1ns
`include "clf_defs.svh"
module clf_config_port
#(
  parameter int TRG_TIMEOUT_CYC = `CLF_TRG_TIMEOUT_CYC
)
(
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        cfg_write_strobe_in,
  input  wire logic [2:0]  cfg_addr_in,
  input  wire logic [6:0]  cfg_data_in,
  input  wire logic        cfg_rd_in,
  output logic      [6:0]  cfg_rdata_out,
  input  wire logic        use_local_clk_n_in,
  input  wire logic        training_clock_in,
  input  wire logic        rate_out_of_range_in,
  input  wire logic [1:0]  amp_level_in,
  input  wire logic        density_low_in,
  input  wire logic        rate_sel_above_low_in,
  input  wire logic        rate_sel_above_high_in,
  output logic             link_fault_n_out,
  output logic             rx_clock_rate_sel_out,
  output logic      [1:0]  sig_detect_amp_sel_out,
  output logic             rx_enable_out,
  output logic             pll_use_training_out,
  output logic      [2:0]  rx_rate_range_out,
  output logic             irq_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Write port: strobe pulse tracked, latch written on its falling edge
  clf_pkg::clf_wr_state_t wr_state_r;
  clf_pkg::clf_wr_state_t wr_state_nxt;
  clf_pkg::clf_cfg_req_t  req_r;
  clf_pkg::clf_cfg_req_t  req_nxt;
  wire logic              wr_commit;

  always_comb
  begin
    wr_state_nxt = wr_state_r;
    req_nxt      = req_r;
    case (wr_state_r)
      clf_pkg::CLF_WR_IDLE:
        if (cfg_write_strobe_in)
        begin
          wr_state_nxt = clf_pkg::CLF_WR_PULSE;
          req_nxt      = '{addr: cfg_addr_in, data: cfg_data_in};
        end
      clf_pkg::CLF_WR_PULSE:
        if (cfg_write_strobe_in)
          req_nxt = '{addr: cfg_addr_in, data: cfg_data_in};
        else
          wr_state_nxt = clf_pkg::CLF_WR_IDLE;
      default:
        wr_state_nxt = clf_pkg::CLF_WR_IDLE;
    endcase
  end

  // Commit uses the value sampled in the last strobe-high cycle
  assign wr_commit = (wr_state_r == clf_pkg::CLF_WR_PULSE) && !cfg_write_strobe_in;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_state_r <= clf_pkg::CLF_WR_IDLE;
      req_r      <= '0;
    end
    else
    begin
      wr_state_r <= wr_state_nxt;
      req_r      <= req_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire logic wr_rx_ctrl;
  wire logic wr_sigdet;
  wire logic wr_power;
  wire logic wr_mask;

  assign wr_rx_ctrl = wr_commit && (req_r.addr == `CLF_ADDR_RX_CTRL);
  assign wr_sigdet  = wr_commit && (req_r.addr == `CLF_ADDR_RX_SIGDET);
  assign wr_power   = wr_commit && (req_r.addr == `CLF_ADDR_RX_POWER);
  assign wr_mask    = wr_commit && (req_r.addr == `CLF_ADDR_IRQ_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration latches
  logic       rx_rate_r;
  logic [1:0] sigdet_r;
  logic       rx_en_r;
  logic [6:0] mask_r;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rx_rate_r <= `CLF_RX_RATE_INIT;
      sigdet_r  <= `CLF_SIGDET_INIT;
      rx_en_r   <= `CLF_RX_EN_INIT;
      mask_r    <= `CLF_IRQ_MASK_INIT;
    end
    else
    begin
      if (wr_rx_ctrl)
        rx_rate_r <= req_r.data[`CLF_RX_CTRL_RATE_BIT];
      if (wr_sigdet)
        sigdet_r <= req_r.data[`CLF_SIGDET_AMP_LSB +: 2];
      if (wr_power)
        rx_en_r <= req_r.data[`CLF_RX_POWER_EN_BIT];
      if (wr_mask)
        mask_r <= req_r.data;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Training clock watchdog: edge seen within the timeout window
  localparam int CW = $clog2(TRG_TIMEOUT_CYC + 1);
  logic          trg_d_r;
  logic [CW-1:0] trg_cnt_r;
  wire logic     trg_edge;
  wire logic     trg_absent;

  assign trg_edge   = training_clock_in ^ trg_d_r;
  assign trg_absent = (trg_cnt_r == CW'(TRG_TIMEOUT_CYC));

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      trg_d_r   <= 1'h0;
      trg_cnt_r <= '0;
    end
    else
    begin
      trg_d_r <= training_clock_in;
      if (trg_edge)
        trg_cnt_r <= '0;
      else if (!trg_absent)
        trg_cnt_r <= trg_cnt_r + CW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Static rate range select
  clf_pkg::clf_level_t rate_level;

  clf_tri_level u_rate_sel
  (
    .clk_in        (clk_in),
    .sys_rst_in    (sys_rst_in),
    .above_low_in  (rate_sel_above_low_in),
    .above_high_in (rate_sel_above_high_in),
    .level_out     (rate_level)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Fault summary
  clf_pkg::clf_fault_t fault;
  wire logic           any_fault;

  // Amplitude detector reports a level 0..3; below selected trip is a fault
  assign fault.amp_low           = (amp_level_in < sigdet_r);
  assign fault.rate_out_of_range = rate_out_of_range_in;
  assign fault.density_low       = density_low_in;
  assign fault.rx_disabled       = !rx_en_r;
  assign fault.local_clk         = !use_local_clk_n_in;
  assign fault.trg_clk_absent    = trg_absent;
  assign any_fault               = |fault;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky per fault cause, cleared by reading
  logic [6:0] stat_r;
  wire  [6:0] stat_set;
  wire  logic rd_stat;

  assign stat_set = {1'h0, fault};
  assign rd_stat  = cfg_rd_in && (cfg_addr_in == `CLF_ADDR_IRQ_STAT);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      stat_r <= 7'h00;
    else
      stat_r <= (rd_stat ? 7'h00 : stat_r) | stat_set;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read back
  logic [6:0] rdata_nxt;

  always_comb
  begin
    case (cfg_addr_in)
      `CLF_ADDR_RX_CTRL:   rdata_nxt = {6'h00, rx_rate_r};
      `CLF_ADDR_RX_SIGDET: rdata_nxt = {5'h00, sigdet_r};
      `CLF_ADDR_RX_POWER:  rdata_nxt = {6'h00, rx_en_r};
      `CLF_ADDR_IRQ_STAT:  rdata_nxt = stat_r;
      `CLF_ADDR_IRQ_MASK:  rdata_nxt = mask_r;
      default:             rdata_nxt = 7'h00;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      cfg_rdata_out          <= 7'h00;
      link_fault_n_out       <= 1'h0;
      rx_clock_rate_sel_out  <= `CLF_RX_RATE_INIT;
      sig_detect_amp_sel_out <= `CLF_SIGDET_INIT;
      rx_enable_out          <= `CLF_RX_EN_INIT;
      pll_use_training_out   <= 1'h1;
      rx_rate_range_out      <= 3'h1;
      irq_out                <= 1'h0;
    end
    else
    begin
      cfg_rdata_out          <= cfg_rd_in ? rdata_nxt : 7'h00;
      link_fault_n_out       <= !any_fault;
      rx_clock_rate_sel_out  <= rx_rate_r;
      sig_detect_amp_sel_out <= sigdet_r;
      rx_enable_out          <= rx_en_r;
      // Any fault, including forced local clock, steers PLL to training clock
      pll_use_training_out   <= any_fault;
      rx_rate_range_out      <= rate_level;
      irq_out                <= |(stat_r & mask_r);
    end
  end

endmodule : clf_config_port

/* File: src/clf_defs.svh */
/*
  Constants of the configuration latch port and link fault logic: latch
  addresses, field positions, initial values and watchdog timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CLF_DEFS_SVH
`define CLF_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// Latch addresses on the configuration address bus
`define CLF_ADDR_W          3
`define CLF_DATA_W          7
`define CLF_ADDR_RX_CTRL    3'h0
`define CLF_ADDR_RX_SIGDET  3'h1
`define CLF_ADDR_RX_POWER   3'h2
`define CLF_ADDR_IRQ_STAT   3'h3
`define CLF_ADDR_IRQ_MASK   3'h4

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CLF_RX_CTRL_RATE_BIT    0
`define CLF_SIGDET_AMP_LSB      0
`define CLF_RX_POWER_EN_BIT     0

////////////////////////////////////////////////////////////////////////////////
// Initial values after reset
`define CLF_RX_RATE_INIT    1'h0
`define CLF_SIGDET_INIT     2'h0
`define CLF_RX_EN_INIT      1'h1
`define CLF_IRQ_MASK_INIT   7'h00

////////////////////////////////////////////////////////////////////////////////
// Training clock watchdog: absent when no edge within this time
`define CLF_TRG_TIMEOUT_NS  400
`define CLF_CLK_PERIOD_NS   40
`define CLF_TRG_TIMEOUT_CYC (`CLF_TRG_TIMEOUT_NS / `CLF_CLK_PERIOD_NS)

`endif

/* File: src/clf_pkg.sv */
/*
  Types of the configuration latch port and link fault logic.
  Assumes the constants header is compiled alongside.
*/
package clf_pkg;

  // Three-level static select decoded value
  typedef enum logic [2:0] {
    CLF_LVL_LOW  = 3'h1,
    CLF_LVL_MID  = 3'h2,
    CLF_LVL_HIGH = 3'h4
  } clf_level_t;

  // Write port states
  typedef enum logic [1:0] {
    CLF_WR_IDLE  = 2'h1,
    CLF_WR_PULSE = 2'h2
  } clf_wr_state_t;

  // Receive-side fault conditions
  typedef struct packed {
    logic rate_out_of_range;
    logic amp_low;
    logic density_low;
    logic rx_disabled;
    logic local_clk;
    logic trg_clk_absent;
  } clf_fault_t;

  // Configuration bus write request
  typedef struct packed {
    logic [2:0] addr;
    logic [6:0] data;
  } clf_cfg_req_t;

endpackage : clf_pkg

/* File: src/clf_tri_level.sv */
/*
  Decoder of one three-level static select input.
  Assumes the pad gives two comparator bits: above the low threshold and
  above the high threshold, synchronous to the clock.
*/
`timescale 1ns/1ns
module clf_tri_level
(
  input  wire logic              clk_in,
  input  wire logic              sys_rst_in,
  input  wire logic              above_low_in,
  input  wire logic              above_high_in,
  output clf_pkg::clf_level_t    level_out
);

  wire clf_pkg::clf_level_t level_nxt;

  // Floating pin self-biases between thresholds and reads as mid
  assign level_nxt = above_high_in ? clf_pkg::CLF_LVL_HIGH :
                     above_low_in  ? clf_pkg::CLF_LVL_MID  :
                                     clf_pkg::CLF_LVL_LOW;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      level_out <= clf_pkg::CLF_LVL_LOW;
    else
      level_out <= level_nxt;
  end

endmodule : clf_tri_level

/* File: verif/clf_config_port_asserts.sv */
/* Port assertions of clf_config_port.
   Assumes a bind to every instance of clf_config_port. */
`timescale 1ns/1ns
module clf_config_port_asserts
(
  input wire logic       clk_in,
  input wire logic       sys_rst_in,
  input wire logic       cfg_write_strobe_in,
  input wire logic [2:0] cfg_addr_in,
  input wire logic [6:0] cfg_data_in,
  input wire logic       cfg_rd_in,
  input wire logic [6:0] cfg_rdata_out,
  input wire logic       use_local_clk_n_in,
  input wire logic       rate_out_of_range_in,
  input wire logic       density_low_in,
  input wire logic       rate_sel_above_low_in,
  input wire logic       rate_sel_above_high_in,
  input wire logic       link_fault_n_out,
  input wire logic       rx_clock_rate_sel_out,
  input wire logic [1:0] sig_detect_amp_sel_out,
  input wire logic       rx_enable_out,
  input wire logic       pll_use_training_out,
  input wire logic [2:0] rx_rate_range_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic [2:0] lvl_w = rate_sel_above_high_in ? 3'h4 : (rate_sel_above_low_in ? 3'h2 : 3'h1);
////////////////////////////////////////////////////////////////////////////////
  rate_fault_a: assert property (rate_out_of_range_in |=> !link_fault_n_out)
    else $error("no link fault on rate out of range");
  lclk_fault_a: assert property (!use_local_clk_n_in |=> !link_fault_n_out)
    else $error("no link fault on forced local clock");
  dens_fault_a: assert property (density_low_in |=> !link_fault_n_out)
    else $error("no link fault on low density");
  pll_follow_a: assert property (pll_use_training_out == !link_fault_n_out)
    else $error("pll source disagrees with link fault");
  rd_idle_a: assert property (!$past(cfg_rd_in) |-> cfg_rdata_out == 7'h00)
    else $error("read data outside its cycle");
  rd_unmapped_a: assert property (
    cfg_rd_in && cfg_addr_in > 3'h4 |=> cfg_rdata_out == 7'h00)
    else $error("unmapped read not zero");
  // Latch moves at the commit edge, its output copy one edge later
  amp_write_a: assert property (
    cfg_write_strobe_in && cfg_addr_in == 3'h1 ##1 !cfg_write_strobe_in
    |=> ##1 sig_detect_amp_sel_out == $past(cfg_data_in[1:0], 3))
    else $error("amp select not written");
  rate_write_a: assert property (
    cfg_write_strobe_in && cfg_addr_in == 3'h0 ##1 !cfg_write_strobe_in
    |=> ##1 rx_clock_rate_sel_out == $past(cfg_data_in[0], 3))
    else $error("rate select not written");
  // A visible change needs a strobe three samples back or a reset one back
  hold_latch_a: assert property (
    !$past(cfg_write_strobe_in, 3) && !$past(sys_rst_in)
    |-> $stable(sig_detect_amp_sel_out) && $stable(rx_clock_rate_sel_out))
    else $error("latch moved");
  init_val_a: assert property (
    $past(sys_rst_in) |-> !rx_clock_rate_sel_out && rx_enable_out
    && sig_detect_amp_sel_out == 2'h0) else $error("latch not at initial value");
  tri_level_a: assert property (!$past(sys_rst_in) && !$past(sys_rst_in, 2)
    |-> rx_rate_range_out == $past(lvl_w, 2)) else $error("rate range decode wrong");
  cover property ($fell(link_fault_n_out));
  cover property (cfg_rd_in ##1 cfg_rdata_out != 7'h00);
  cover property (cfg_write_strobe_in && cfg_addr_in == 3'h1 ##1 !cfg_write_strobe_in);
endmodule : clf_config_port_asserts

bind clf_config_port clf_config_port_asserts u_clf_config_port_asserts (.clk_in, .sys_rst_in,
  .cfg_write_strobe_in, .cfg_addr_in, .cfg_data_in, .cfg_rd_in, .cfg_rdata_out,
  .use_local_clk_n_in, .rate_out_of_range_in, .density_low_in, .rate_sel_above_low_in,
  .rate_sel_above_high_in, .link_fault_n_out, .rx_clock_rate_sel_out,
  .sig_detect_amp_sel_out, .rx_enable_out, .pll_use_training_out, .rx_rate_range_out);

/* File: verif/clf_host_model.sv */
/* Host driving the configuration bus.
   Assumes go_in is raised for one cycle per transfer. */
`timescale 1ns/1ns
module clf_host_model
(
  input  wire logic       clk_in,
  input  wire logic       go_in,
  input  wire logic       wr_in,
  input  wire logic [2:0] addr_in,
  input  wire logic [6:0] data_in,
  output logic            strobe_out = 1'b0,
  output logic            rd_out = 1'b0,
  output logic      [2:0] addr_out = 3'h0,
  output logic      [6:0] data_out = 7'h00
);
  always @(posedge clk_in)
  begin
    strobe_out <= go_in & wr_in;
    rd_out     <= go_in & ~wr_in;
    // Bus wanders outside a transfer, so a latch that samples it stands out
    addr_out   <= go_in ? addr_in : ~addr_out;
    data_out   <= go_in ? data_in : ~data_out;
  end
endmodule : clf_host_model

/* File: verif/test_config_latch_port_link_fault.sv */
/* Self-checking bench of clf_config_port with a host model on its bus.
   Assumes header, package and design are compiled first. */
`timescale 1ns/1ns
`include "clf_defs.svh"
module test_config_latch_port_link_fault;
  localparam int TRG = 4;
  logic       clk_in = 1'b0;
  logic       sys_rst_in = 1'b1;
  logic       go = 1'b0, wr = 1'b0, trg = 1'b0, alo = 1'b0, ahi = 1'b0;
  logic [3:0] f = 4'h0;
  logic [1:0] amp = 2'h0, amp_sel;
  logic [2:0] ad = 3'h0, bus_a, range;
  logic [6:0] dt = 7'h00, bus_d, rdata;
  logic       stb, rd, lfn, rate_sel, rx_en, pll, irq;
  int         errors = 0, cmp_count = 0;

  always #20 clk_in = ~clk_in;
  // Training clock stands still while f[3] is set
  always @(posedge clk_in) if (!f[3]) trg <= ~trg;

  clf_host_model u_clf_host_model (.clk_in, .go_in(go), .wr_in(wr), .addr_in(ad),
    .data_in(dt), .strobe_out(stb), .rd_out(rd), .addr_out(bus_a), .data_out(bus_d));
  clf_config_port #(.TRG_TIMEOUT_CYC(TRG)) u_clf_config_port (.clk_in, .sys_rst_in,
    .cfg_write_strobe_in(stb), .cfg_addr_in(bus_a), .cfg_data_in(bus_d), .cfg_rd_in(rd),
    .cfg_rdata_out(rdata), .use_local_clk_n_in(~f[1]), .training_clock_in(trg),
    .rate_out_of_range_in(f[0]), .amp_level_in(amp), .density_low_in(f[2]),
    .rate_sel_above_low_in(alo), .rate_sel_above_high_in(ahi), .link_fault_n_out(lfn),
    .rx_clock_rate_sel_out(rate_sel), .sig_detect_amp_sel_out(amp_sel),
    .rx_enable_out(rx_en), .pll_use_training_out(pll), .rx_rate_range_out(range),
    .irq_out(irq));
////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [6:0] got, input logic [6:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : settle

  // Reads leave rdata readable on return; writes leave the output copy settled
  task automatic xfer(input logic w, input logic [2:0] a, input logic [6:0] d);
    @(posedge clk_in);
    go <= 1'b1;
    wr <= w;
    ad <= a;
    dt <= d;
    @(posedge clk_in);
    go <= 1'b0;
    settle(w ? 3 : 1);
  endtask : xfer

  task automatic lf_chk(input logic ok);
    settle(TRG + 4);
    chk({5'h00, pll, lfn}, ok ? 7'h01 : 7'h02);
  endtask : lf_chk

  task automatic conclude;
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle(3);
    chk({3'h0, amp_sel, rate_sel, rx_en}, 7'h01);
    lf_chk(1'b1);
    for (int v = 0; v < 4; v++)
    begin
      xfer(1'b1, `CLF_ADDR_RX_SIGDET, 7'h7C | v[6:0]);
      chk({5'h00, amp_sel}, v[6:0]);
      @(posedge clk_in) amp <= v[1:0] - 2'h1;
      lf_chk(v == 0);
      @(posedge clk_in) amp <= v[1:0];
      lf_chk(1'b1);
    end
    xfer(1'b1, `CLF_ADDR_RX_CTRL, 7'h01);
    xfer(1'b1, 3'h5, 7'h00);
    settle(4);
    chk({4'h0, amp_sel, rate_sel}, 7'h07);
    xfer(1'b0, `CLF_ADDR_RX_CTRL, 7'h00);
    chk(rdata, 7'h01);
    xfer(1'b0, `CLF_ADDR_RX_SIGDET, 7'h00);
    chk(rdata, 7'h03);
    xfer(1'b0, 3'h5, 7'h00);
    chk(rdata, 7'h00);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_in) f <= 4'h1 << i;
      lf_chk(1'b0);
      @(posedge clk_in) f <= 4'h0;
      lf_chk(1'b1);
    end
    xfer(1'b1, `CLF_ADDR_RX_POWER, 7'h00);
    lf_chk(1'b0);
    xfer(1'b1, `CLF_ADDR_RX_POWER, 7'h01);
    lf_chk(1'b1);
    xfer(1'b0, `CLF_ADDR_IRQ_STAT, 7'h00);
    xfer(1'b1, `CLF_ADDR_IRQ_MASK, 7'h08);
    xfer(1'b0, `CLF_ADDR_IRQ_MASK, 7'h00);
    chk(rdata, 7'h08);
    @(posedge clk_in) f <= 4'h1;
    lf_chk(1'b0);
    chk({6'h00, irq}, 7'h00);
    @(posedge clk_in) f <= 4'h4;
    settle(3);
    @(posedge clk_in) f <= 4'h0;
    lf_chk(1'b1);
    chk({6'h00, irq}, 7'h01);
    xfer(1'b0, `CLF_ADDR_IRQ_STAT, 7'h00);
    chk(rdata, 7'h28);
    settle(2);
    chk({6'h00, irq}, 7'h00);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_in) {ahi, alo} <= 2'((1 << i) - 1);
      settle(3);
      chk({4'h0, range}, 7'(1 << i));
    end
    @(posedge clk_in) sys_rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    settle(3);
    chk({3'h0, amp_sel, rate_sel, rx_en}, 7'h01);
    conclude();
  end

  initial
  begin
    #200000;
    errors++;
    conclude();
  end
endmodule : test_config_latch_port_link_fault
